/* logic/tfg_pkg.sv */
// Constants, register layout and shared functions of the test frame generator.
package tfg_pkg;

   // ----------------------------------------------------------------------
   // Register addresses within the extended management page
   // ----------------------------------------------------------------------
   localparam logic [4:0]  CTRL_ADDR     = 5'h1D;    // Generator control register.
   localparam logic [4:0]  PAT_ADDR      = 5'h1E;    // Payload pattern register.

   // ----------------------------------------------------------------------
   // Field positions of the generator control register
   // ----------------------------------------------------------------------
   localparam int          BIT_EN        = 15;       // Generator enable.
   localparam int          BIT_RUN       = 14;       // Run or stop.
   localparam int          BIT_DUR       = 13;       // 1 continuous, 0 fixed count.
   localparam int          LEN_HI        = 12;       // Length select, upper bit.
   localparam int          LEN_LO        = 11;       // Length select, lower bit.
   localparam int          BIT_GAP       = 10;       // 1 long gap, 0 short gap.
   localparam int          DA_HI         = 9;        // Destination nibble, upper bit.
   localparam int          DA_LO         = 6;        // Destination nibble, lower bit.
   localparam int          SA_HI         = 5;        // Source nibble, upper bit.
   localparam int          SA_LO         = 2;        // Source nibble, lower bit.
   localparam int          BIT_PTYPE     = 1;        // 1 random payload, 0 fixed.
   localparam int          BIT_BADFCS    = 0;        // 1 corrupt the FCS.

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [15:0] CTRL_RESET    = 16'h0040; // Destination nibble 0001.
   localparam logic [15:0] PAT_RESET     = 16'h0000; // Fixed pattern of zero.

   // ----------------------------------------------------------------------
   // Frame sizes, counts and gaps
   // ----------------------------------------------------------------------
   localparam logic [13:0] LEN_125       = 14'h007D; // Length code 00.
   localparam logic [13:0] LEN_64        = 14'h0040; // Length code 01.
   localparam logic [13:0] LEN_1518      = 14'h05EE; // Length code 10.
   localparam logic [13:0] LEN_10000     = 14'h2710; // Length code 11.
   localparam logic [13:0] HDR_LEN       = 14'h000E; // Addresses plus type field.
   localparam logic [13:0] FCS_LEN       = 14'h0004; // Check sequence bytes.
   localparam int unsigned TOTAL_FRAMES  = 30000000; // Frames in a fixed-count run.
   localparam int unsigned BLOCK_SIZE    = 10000;    // Frames per continuous block.
   localparam int unsigned IPG_SHORT_BITS = 96;      // Short gap in bit times.
   localparam int unsigned IPG_LONG_BITS = 8192;     // Long gap in bit times.
   localparam int unsigned BITS_PER_CYCLE = 8;       // One byte leaves per clock.
   localparam logic [10:0] GAP_SHORT_CYC = 11'(IPG_SHORT_BITS / BITS_PER_CYCLE);
   localparam logic [10:0] GAP_LONG_CYC  = 11'(IPG_LONG_BITS / BITS_PER_CYCLE);

   // ----------------------------------------------------------------------
   // Frame contents
   // ----------------------------------------------------------------------
   localparam logic [15:0] ETH_TYPE      = 16'h88B5; // Type field of test frames.
   localparam logic [31:0] CRC_POLY      = 32'hEDB88320; // Reflected CRC-32.
   localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF; // CRC start value.
   localparam logic [15:0] LFSR_SEED     = 16'hACE1;     // Random payload seed.

   // Maps the two-bit length select onto a frame length in bytes.
   function automatic logic [13:0] tfg_len(input logic [1:0] sel);
      logic [13:0] r;
      r = LEN_125;
      case (sel)
         2'h1:    r = LEN_64;
         2'h2:    r = LEN_1518;
         2'h3:    r = LEN_10000;
         default: r = LEN_125;
      endcase
      return r;
   endfunction : tfg_len

   // Advances the reflected CRC-32 by one byte, least significant bit first.
   function automatic logic [31:0] tfg_crc_next(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : tfg_crc_next

endpackage : tfg_pkg

/* logic/tfg_buf2.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module tfg_buf2 #(
   parameter int W = 10                          // Word width.
)(
   input  wire logic         clk_sys,            // System clock.
   input  wire logic         rstn,               // Asynchronous reset, active low.
   input  wire logic [W-1:0] in_data,            // Word offered by the source.
   input  wire logic         in_valid,           // Source offers a word.
   output logic              in_ready,           // Buffer can take a word.
   output logic [W-1:0]      out_data,           // Oldest word held.
   output logic              out_valid,          // A word is held.
   input  wire logic         out_ready           // Sink takes the word.
);

   // ----------------------------------------------------------------------
   // Storage and occupancy
   // ----------------------------------------------------------------------
   logic [W-1:0] slot1;                          // Second word behind out_data.
   logic [1:0]   cnt;                            // Words held, 0 to 2.
   logic [1:0]   next_cnt;                       // Occupancy after this edge.
   wire          push = in_valid & in_ready;     // Word enters.
   wire          pop  = out_valid & out_ready;   // Word leaves.

   assign next_cnt = cnt + {1'b0, push} - {1'b0, pop};

   // Moves words so that out_data always holds the oldest one.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         out_data  <= '0;
         slot1     <= '0;
         cnt       <= 2'h0;
         out_valid <= 1'b0;
         in_ready  <= 1'b1;
      end
      else
      begin
         if (pop)
         begin
            // The second word moves up, or the new one if only one was held.
            out_data <= (cnt == 2'h2) ? slot1 : in_data;
         end
         else if (push && cnt == 2'h0)
         begin
            out_data <= in_data;
         end
         if (push && ((cnt == 2'h1 && !pop) || (cnt == 2'h2 && pop)))
         begin
            slot1 <= in_data;
         end
         cnt       <= next_cnt;
         out_valid <= (next_cnt != 2'h0);
         in_ready  <= (next_cnt != 2'h2);
      end
   end

endmodule : tfg_buf2

/* logic/tfg_top.sv */
// Test frame generator: registers, frame builder, counters and output buffer.
//
// Summary of operation
// - Fixed mode sends thirty million frames, stops.
// - Continuous mode stops at next ten-thousand mark once the duration bit is cleared.
// - Length field and gap bit set size, gap.
// - Destination low nibble from control bits 9:6.
// - Source low nibble from control bits 5:2.
// - Payload type picks random or fixed pattern.
// - Bad-FCS bit corrupts every frame check sequence.
// - Fixed payload repeats sixteen-bit pattern register.
// - Control changes apply after run restart, except clearing the duration, run or enable bit.
// - Pattern changes apply after run restart.
`timescale 1ns/1ps
module tfg_top
   import tfg_pkg::*;
#(
   parameter int unsigned FRAME_LIMIT  = TOTAL_FRAMES, // Frames in a fixed-count run.
   parameter int unsigned BLOCK_FRAMES = BLOCK_SIZE    // Frames per continuous block.
)(
   input  wire logic        clk_sys,             // System clock, 40 MHz.
   input  wire logic        rstn,                // Asynchronous reset, active low.
   input  wire logic [4:0]  reg_addr,            // Management register address.
   input  wire logic        reg_wr,              // Write strobe.
   input  wire logic        reg_rd,              // Read strobe.
   input  wire logic [15:0] reg_wdata,           // Write data.
   output logic      [15:0] reg_rdata,           // Read data, one cycle after reg_rd.
   output logic      [7:0]  tx_data,             // Frame byte toward the media.
   output logic             tx_first,            // Byte opens a frame.
   output logic             tx_last,             // Byte closes a frame.
   output logic             tx_valid,            // A byte is offered.
   input  wire logic        tx_ready,            // Media side takes the byte.
   output logic             gen_active           // Generator is running a test.
);

   // ----------------------------------------------------------------------
   // Types and state
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_GAP} tfg_state_t;

   tfg_state_t  state;                           // Frame builder state.
   logic [15:0] ctl;                             // Generator control register.
   logic [15:0] pat;                             // Payload pattern register.
   logic        go_q;                            // Enable and run, one cycle ago.
   logic [13:0] len_q;                           // Frame length taken at start.
   logic [10:0] gap_q;                           // Gap cycles taken at start.
   logic [3:0]  da_q;                            // Destination nibble taken at start.
   logic [3:0]  sa_q;                            // Source nibble taken at start.
   logic        rnd_q;                           // Random payload taken at start.
   logic        bad_q;                           // Bad FCS taken at start.
   logic        dur_q;                           // Duration mode taken at start.
   logic [15:0] pat_q;                           // Pattern taken at start.
   logic [13:0] idx;                             // Byte position within the frame.
   logic [10:0] gap_cnt;                         // Cycles spent in the gap.
   logic [24:0] frame_cnt;                       // Frames sent in this run.
   logic [13:0] block_cnt;                       // Frames sent in this block.
   logic [31:0] crc;                             // Running CRC over the frame.
   logic [15:0] lfsr;                            // Random payload source.

   // ----------------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------------
   wire         wr_ctl   = reg_wr & (reg_addr == CTRL_ADDR);  // Control write.
   wire         wr_pat   = reg_wr & (reg_addr == PAT_ADDR);   // Pattern write.
   wire  [15:0] rd_mux   = (reg_addr == CTRL_ADDR) ? ctl :
                           (reg_addr == PAT_ADDR)  ? pat : 16'h0000;

   // ----------------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------------
   wire         go       = ctl[BIT_EN] & ctl[BIT_RUN];
   wire         start    = go & ~go_q;                        // Enable and run rose.
   wire         buf_ready;                                    // Buffer has room.
   wire         push     = go & (state == ST_FRAME) & buf_ready; // Byte enters.
   wire  [13:0] fcs_pos  = len_q - FCS_LEN;                   // First FCS byte.
   wire         frame_end = push & (idx == len_q - 14'h0001); // Last byte enters.
   wire         block_end = (block_cnt == 14'(BLOCK_FRAMES - 1));
   wire         limit_end = (frame_cnt == 25'(FRAME_LIMIT - 1));
   // The duration bit is read live so that clearing it ends the run at the
   // next block mark; enable and run are also read live, all other fields are frozen at start.
   wire         run_done = frame_end &
                           (dur_q ? (~ctl[BIT_DUR] & block_end)
                                  : limit_end);
   wire         gap_done = (gap_cnt == gap_q - 11'h001);      // Gap complete.

   // ----------------------------------------------------------------------
   // Byte selection
   // ----------------------------------------------------------------------
   wire  [13:0] pay_off  = idx - HDR_LEN;                     // Offset in payload.
   wire  [1:0]  fcs_k    = 2'(idx - fcs_pos);                 // FCS byte number.
   wire  [31:0] fcs_word = bad_q ? crc : ~crc;
   wire  [7:0]  fcs_byte = fcs_word[{fcs_k, 3'h0} +: 8];      // Low byte first.
   wire  [7:0]  fix_byte = pay_off[0] ? pat_q[7:0] : pat_q[15:8];
   wire  [7:0]  pay_byte = rnd_q ? lfsr[7:0] : fix_byte;
   wire         in_fcs   = (idx >= fcs_pos);                  // FCS bytes.
   wire         in_pay   = (idx >= HDR_LEN) & ~in_fcs;        // Payload bytes.
   logic [7:0]  frame_byte;                                   // Byte for idx.

   // Builds the frame byte for the current position.
   always_comb
   begin
      frame_byte = 8'hFF;                        // Broadcast-style address bytes.
      if (in_fcs)
      begin
         frame_byte = fcs_byte;
      end
      else if (in_pay)
      begin
         frame_byte = pay_byte;
      end
      else if (idx == 14'h0005)
      begin
         frame_byte = {4'hF, da_q};
      end
      else if (idx == 14'h000B)
      begin
         frame_byte = {4'hF, sa_q};
      end
      else if (idx == 14'h000C)
      begin
         frame_byte = ETH_TYPE[15:8];            // Type field, high byte.
      end
      else if (idx == 14'h000D)
      begin
         frame_byte = ETH_TYPE[7:0];             // Type field, low byte.
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // Software writes win, so a set of the run bit in the cycle that a run
   // finishes is kept; otherwise the run bit drops when the run is done.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl <= CTRL_RESET;
         pat <= PAT_RESET;
      end
      else
      begin
         if (wr_ctl)
         begin
            ctl <= reg_wdata;
         end
         else if (run_done)
         begin
            ctl[BIT_RUN] <= 1'b0;
         end
         if (wr_pat)
         begin
            pat <= reg_wdata;
         end
      end
   end

   // Returns read data one cycle after the strobe and holds it afterwards.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rdata <= 16'h0000;
      end
      else if (reg_rd)
      begin
         reg_rdata <= rd_mux;
      end
   end

   // ----------------------------------------------------------------------
   // Configuration capture
   // ----------------------------------------------------------------------
   // Fields are frozen on the rising run edge, so changes made while
   // running wait for the run bit to be cleared and set again.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         go_q  <= 1'b0;
         len_q <= LEN_125;
         gap_q <= GAP_SHORT_CYC;
         da_q  <= 4'h0;
         sa_q  <= 4'h0;
         rnd_q <= 1'b0;
         bad_q <= 1'b0;
         dur_q <= 1'b0;
         pat_q <= PAT_RESET;
      end
      else
      begin
         go_q <= go;
         if (start)
         begin
            len_q <= tfg_len(ctl[LEN_HI:LEN_LO]);
            gap_q <= ctl[BIT_GAP] ? GAP_LONG_CYC : GAP_SHORT_CYC;
            da_q  <= ctl[DA_HI:DA_LO];
            sa_q  <= ctl[SA_HI:SA_LO];
            rnd_q <= ctl[BIT_PTYPE];
            bad_q <= ctl[BIT_BADFCS];
            dur_q <= ctl[BIT_DUR];
            pat_q <= pat;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Frame builder
   // ----------------------------------------------------------------------
   // Walks frame bytes and gaps; dropping enable or run halts at once.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state   <= ST_IDLE;
         idx     <= 14'h0000;
         gap_cnt <= 11'h000;
      end
      else if (!go)
      begin
         state <= ST_IDLE;
         idx   <= 14'h0000;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (start)
               begin
                  state <= ST_FRAME;             // New run, first frame.
                  idx   <= 14'h0000;
               end
            end
            ST_FRAME:
            begin
               if (frame_end)
               begin
                  state   <= run_done ? ST_IDLE : ST_GAP;
                  gap_cnt <= 11'h000;
                  idx     <= 14'h0000;
               end
               else if (push)
               begin
                  idx <= idx + 14'h0001;         // Next byte.
               end
            end
            ST_GAP:
            begin
               gap_cnt <= gap_cnt + 11'h001;
               if (gap_done)
               begin
                  state <= ST_FRAME;
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Counts frames, updates the CRC and steps the random source.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         frame_cnt <= 25'h0000000;
         block_cnt <= 14'h0000;
         crc       <= CRC_INIT;
         lfsr      <= LFSR_SEED;
         gen_active <= 1'b0;
      end
      else
      begin
         gen_active <= go & (state != ST_IDLE || start);
         if (start)
         begin
            frame_cnt <= 25'h0000000;
            block_cnt <= 14'h0000;
            lfsr      <= LFSR_SEED;
         end
         else if (frame_end)
         begin
            frame_cnt <= frame_cnt + 25'h0000001;
            block_cnt <= block_end ? 14'h0000 : block_cnt + 14'h0001;
         end
         if (start || frame_end)
         begin
            crc <= CRC_INIT;
         end
         else if (push && !in_fcs)
         begin
            crc <= tfg_crc_next(crc, frame_byte);
         end
         if (push && in_pay && rnd_q)
         begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Output buffer
   // ----------------------------------------------------------------------
   tfg_buf2 #(
      .W         (10)
   ) u_buf (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_data   ({idx == 14'h0000, frame_end, frame_byte}),
      .in_valid  (go & (state == ST_FRAME)),
      .in_ready  (buf_ready),
      .out_data  ({tx_first, tx_last, tx_data}),
      .out_valid (tx_valid),
      .out_ready (tx_ready)
   );

endmodule : tfg_top

/* testbench/tfg_assertions.sv */
// Port checks of the test frame generator.
`timescale 1ns/1ps
module tfg_checker
   import tfg_pkg::*;
(
   input wire logic        clk_sys,    // System clock.
   input wire logic        rstn,       // Reset, active low.
   input wire logic [4:0]  reg_addr,   // Register address.
   input wire logic        reg_wr,     // Write strobe.
   input wire logic        reg_rd,     // Read strobe.
   input wire logic [15:0] reg_wdata,  // Write data.
   input wire logic [15:0] reg_rdata,  // Read data.
   input wire logic [7:0]  tx_data,    // Frame byte.
   input wire logic        tx_first,   // Byte opens a frame.
   input wire logic        tx_last,    // Byte closes a frame.
   input wire logic        tx_valid,   // Byte offered.
   input wire logic        tx_ready,   // Byte taken.
   input wire logic        gen_active  // Run in progress.
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Start write while idle.
   sequence s_go;
      reg_wr && reg_addr == CTRL_ADDR && &reg_wdata[15:14] && !gen_active;
   endsequence
   // Write, idle cycle, read back.
   sequence s_wr_rd(a);
      reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == a;
   endsequence
   property p_start; s_go |-> ##[1:2] gen_active; endproperty
   property p_first; s_go |-> ##[2:3] (tx_valid && tx_first && tx_data == 8'hFF); endproperty
   property p_abort;
      reg_wr && reg_addr == CTRL_ADDR && !reg_wdata[14] && gen_active |-> ##[1:2] !gen_active;
   endproperty
   property p_drain; (!gen_active && tx_ready) [*5] |-> !tx_valid; endproperty
   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
   endproperty
   property p_single; tx_valid && tx_last |-> !tx_first; endproperty
   property p_patrd; s_wr_rd(PAT_ADDR) |=> reg_rdata == $past(reg_wdata, 3); endproperty
   property p_ctlrd;
      s_wr_rd(CTRL_ADDR) |=> reg_rdata[13:0] == $past(reg_wdata[13:0], 3);
   endproperty
   a_start: assert property (p_start) else $error("no start");
   a_first: assert property (p_first) else $error("no first byte");
   a_abort: assert property (p_abort) else $error("no stop");
   a_drain: assert property (p_drain) else $error("bytes after stop");
   a_hold: assert property (p_hold) else $error("byte changed in stall");
   a_single: assert property (p_single) else $error("first and last");
   a_patrd: assert property (p_patrd) else $error("pattern readback");
   a_ctlrd: assert property (p_ctlrd) else $error("control readback");
endmodule : tfg_checker
bind tfg_top tfg_checker tfg_checker_inst (.clk_sys(clk_sys), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .gen_active(gen_active));

/* testbench/tfg_sink.sv */
// Link partner with random stalls.
`timescale 1ns/1ps
module tfg_sink (
   input  wire logic       clk_sys,   // System clock.
   input  wire logic       rstn,      // Reset, active low.
   input  wire logic [7:0] tx_data,   // Frame byte.
   input  wire logic       tx_first,  // Byte opens a frame.
   input  wire logic       tx_last,   // Byte closes a frame.
   input  wire logic       tx_valid,  // Byte offered.
   output logic            tx_ready,  // Byte taken.
   input  wire logic [1:0] stall      // Stall level, 0 never stalls.
);
   logic [8:0] rx [$];                // Bytes taken, tx_last on top.
   int         gap;                   // Cycles from close to open.
   int         cyc;                   // Cycles since a close.
   // Lab loop partner, never a live network.
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready)
      begin
         rx.push_back({tx_last, tx_data});
         if (tx_last) cyc <= 1;
         if (tx_first) gap <= cyc;
      end
      tx_ready <= #1 rstn && ($urandom_range(3) >= stall);
   end
endmodule : tfg_sink

/* testbench/tb_top.sv */
// Self-checking bench of the test frame generator.
`timescale 1ns/1ps
module tb_top;
   import tfg_pkg::*;
   logic        clk_sys = 1'b0;   // System clock.
   logic        rstn = 1'b0;      // Reset, active low.
   logic        reg_wr = 1'b0;    // Write strobe.
   logic        reg_rd = 1'b0;    // Read strobe.
   logic [4:0]  reg_addr = 5'h00; // Register address.
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv, ctl, pat; // Bus and test data.
   logic [7:0]  tx_data;          // Frame byte.
   logic        tx_first, tx_last, tx_valid, tx_ready, gen_active; // Stream and status.
   logic [1:0]  stall = 2'h0;     // Partner stall level.
   int          bad_count = 0;    // Mismatches.
   int          checks = 0;       // Comparisons.
   tfg_top #(.FRAME_LIMIT(5), .BLOCK_FRAMES(2)) tfg_top_inst (.clk_sys(clk_sys), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .gen_active(gen_active));
   tfg_sink tfg_sink_inst (.clk_sys(clk_sys), .rstn(rstn), .tx_data(tx_data),
      .tx_first(tx_first), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .stall(stall));
   initial forever #12.5 clk_sys = ~clk_sys;
   // Counts and reports a comparison.
   task automatic cmp(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp
   task automatic end_of_test();
      if (bad_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   // Register write and read.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys) #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk_sys) #1 reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a);
      @(posedge clk_sys) #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys) #1 reg_rd = 1'b0;
      @(posedge clk_sys) #1 rv = reg_rdata;
   endtask : rd
   // Reflected CRC-32 over one byte.
   function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
      return c;
   endfunction : crc8
   // Waits out the run, checks n frames and readback r.
   task automatic fin(input int n, input logic [15:0] c, p, r);
      logic [8:0]  b;
      logic [7:0]  e;
      logic [31:0] crc, fcs;
      int          len, dif;
      len = c[12] ? (c[11] ? 10000 : 1518) : (c[11] ? 64 : 125);
      repeat (3) @(posedge clk_sys);
      for (int t = 0; t < 60000 && gen_active === 1'b1; t++) @(posedge clk_sys);
      repeat (40) @(posedge clk_sys);
      for (int f = 0; f < n; f++)
      begin
         crc = CRC_INIT;
         dif = 0;
         for (int k = 0; k < len; k++)
         begin
            b = tfg_sink_inst.rx.pop_front();
            if (k == len - 4) fcs = c[0] ? crc : ~crc;
            e = (k == 5) ? {4'hF, c[9:6]} : (k == 11) ? {4'hF, c[5:2]} : (k < 12) ? 8'hFF :
                (k == 12) ? 8'h88 : (k == 13) ? 8'hB5 : (k >= len - 4) ? fcs[7:0] :
                (k % 2 == 0) ? p[15:8] : p[7:0];
            if (k >= 14 && k < len - 4 && b[7:0] != e) dif++;
            if (k >= 14 && k < len - 4 && c[1]) e = b[7:0];
            cmp("frame byte", b, {k == len - 1, e});
            if (k >= len - 4) fcs = fcs >> 8;
            else crc = crc8(crc, b[7:0]);
         end
         cmp("payload kind", dif != 0, c[1]);
      end
      cmp("extra bytes", tfg_sink_inst.rx.size(), 0);
      rd(CTRL_ADDR);
      cmp("control after run", rv, r);
   endtask : fin
   // Reset values, lengths, modes, restart and abort.
   initial
   begin
      void'($urandom(83386));
      repeat (8) @(posedge clk_sys);
      #1 rstn = 1'b1;
      rd(CTRL_ADDR);
      cmp("control reset", rv, 16'h0040);
      rd(PAT_ADDR);
      cmp("pattern reset", rv, 16'h0000);
      rd(5'h10);
      cmp("unmapped read", rv, 16'h0000);
      wr(PAT_ADDR, 16'hA55A);
      rd(PAT_ADDR);
      cmp("pattern readback", rv, 16'hA55A);
      wr(CTRL_ADDR, 16'h0FFF);
      rd(CTRL_ADDR);
      cmp("control readback", rv, 16'h0FFF);
      for (int i = 0; i < 4; i++)
      begin
         stall = (i < 2) ? 2'($urandom_range(2, 1)) : 2'h0;
         ctl = {3'h6, 2'(i), i[0], 8'($urandom), 2'(i)};
         pat = 16'($urandom);
         wr(PAT_ADDR, pat);
         wr(CTRL_ADDR, ctl);
         fin(5, ctl, pat, ctl & 16'hBFFF);
         if (stall == 2'h0) cmp("gap", tfg_sink_inst.gap, ctl[10] ? 32'h401 : 32'hD);
      end
      stall = 2'h0;
      wr(CTRL_ADDR, 16'hE000);
      repeat (300) @(posedge clk_sys);
      wr(CTRL_ADDR, 16'hC000);
      fin(4, 16'hC000, pat, 16'h8000);
      wr(PAT_ADDR, 16'h5AA5);
      wr(CTRL_ADDR, 16'hC840);
      repeat (30) @(posedge clk_sys);
      wr(PAT_ADDR, 16'h0FF0);
      wr(CTRL_ADDR, 16'hC87C);
      fin(5, 16'hC840, 16'h5AA5, 16'h887C);
      wr(CTRL_ADDR, 16'hC87C);
      fin(5, 16'hC87C, 16'h0FF0, 16'h887C);
      wr(CTRL_ADDR, 16'hC800);
      repeat (20) @(posedge clk_sys);
      wr(CTRL_ADDR, 16'h8800);
      repeat (20) @(posedge clk_sys);
      cmp("abort active", gen_active, 1'b0);
      rv = 16'h0000;
      while (tfg_sink_inst.rx.size() > 0) rv |= 16'(tfg_sink_inst.rx.pop_front() >> 8);
      cmp("abort close", rv, 16'h0000);
      wr(CTRL_ADDR, 16'hC800);
      fin(5, 16'hC800, 16'h0FF0, 16'h8800);
      end_of_test();
   end
   // Ends a hang after the longest run.
   initial
   begin
      #2500000;
      bad_count++;
      end_of_test();
   end
endmodule : tb_top
